// ==== rtl/pdpc_pkg.sv ====
// package: register map, field positions, codes and timing for the phy diag/power block
package pdpc_pkg;
  // byte register offsets
  localparam logic [7:0] P1_SPECIAL_OFS = 8'h1A;
  localparam logic [7:0] P1_RESULT_OFS  = 8'h1B;
  localparam logic [7:0] P1_CTRL13_OFS  = 8'h1D;
  localparam logic [7:0] P2_SPECIAL_OFS = 8'h2A;
  localparam logic [7:0] P2_RESULT_OFS  = 8'h2B;
  localparam logic [7:0] P2_CTRL13_OFS  = 8'h2D;
  localparam logic [7:0] PWR_MGMT_OFS   = 8'hC3;
  localparam logic [7:0] SLEEP_DLY_OFS  = 8'hC4;
  localparam logic [7:0] FIBER_CFG_OFS  = 8'hC0;
  // special control/status fields
  localparam int SPC_DIST_MSB_BIT = 0;
  localparam int SPC_START_BIT    = 4;
  localparam int SPC_RES_LO_BIT   = 5;
  // port control 13 fields
  localparam int CTL_XOVER_DIS_BIT = 2;
  localparam int CTL_PWRDN_BIT     = 3;
  localparam int CTL_XOVER_STD_BIT = 4;
  // fiber config fields
  localparam int FIB_THR_BIT   = 6;
  localparam int FIB_FAULT_EN_BIT = 5;
  localparam logic [7:0] FIBER_CFG_RST = 8'h20;
  // cable test result codes
  localparam logic [1:0] RES_NORMAL = 2'h0;
  localparam logic [1:0] RES_OPEN   = 2'h1;
  localparam logic [1:0] RES_SHORT  = 2'h2;
  localparam logic [1:0] RES_FAILED = 2'h3;
  // global power mode codes
  localparam logic [1:0] PWR_NORMAL  = 2'h0;
  localparam logic [1:0] PWR_ENERGY  = 2'h1;
  localparam logic [1:0] PWR_SOFTDN  = 2'h2;
  localparam logic [1:0] PWR_SAVING  = 2'h3;
  localparam logic [7:0] PWR_MGMT_RST = 8'h00;
  localparam logic [7:0] SLEEP_DLY_RST = 8'h50;
  localparam logic [7:0] CTRL13_RST   = 8'h00;
  // far-end fault pattern: ones then a single zero
  localparam int FAULT_ONES = 84;
  // timing
  localparam int CLK_MHZ         = 125;
  localparam int QUIET_WAIT_NS   = 800;
  localparam int QUIET_WAIT_CYC  = (QUIET_WAIT_NS * CLK_MHZ + 999) / 1000;
  localparam int SLEEP_TICK_US   = 10;
  localparam int SLEEP_TICK_CYC  = SLEEP_TICK_US * CLK_MHZ;
  localparam int TDR_WIN_CYC     = 512;
endpackage : pdpc_pkg

// ==== rtl/pdpc_fef_tx.sv ====
// far-end fault signalling generator for one fiber port
`timescale 1ns/1ps
`default_nettype none
module pdpc_fault_tx #(
  parameter int ONES = pdpc_pkg::FAULT_ONES
) (
  input  wire logic CLK,
  input  wire logic SYS_RST,
  input  wire logic fault,
  input  wire logic idle_gap,
  output logic      bit_valid,
  output logic      bit_value
);
  logic [7:0] cnt_q, cnt_d;
  logic       v_q, v_d, b_q, b_d;

  always_comb begin
    cnt_d = cnt_q;
    v_d   = 1'b0;
    b_d   = 1'b0;
    // pattern only goes out between frames; a new frame restarts it
    if (fault && idle_gap) begin
      v_d = 1'b1;
      if (cnt_q < 8'(ONES)) begin
        b_d   = 1'b1;
        cnt_d = cnt_q + 8'h01;
      end else begin
        b_d   = 1'b0;
        cnt_d = 8'h00;
      end
    end else begin
      cnt_d = 8'h00;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cnt_q <= 8'h00;
      v_q   <= 1'b0;
      b_q   <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      v_q   <= v_d;
      b_q   <= b_d;
    end
  end

  assign bit_valid = v_q;
  assign bit_value = b_q;
endmodule // pdpc_fault_tx
`default_nettype wire

// ==== rtl/pdpc_cable_diag.sv ====
// cable diagnostic sequencer for one copper port
`timescale 1ns/1ps
`default_nettype none
module pdpc_cable_diag #(
  parameter int QUIET_CYC = pdpc_pkg::QUIET_WAIT_CYC,
  parameter int WIN_CYC   = pdpc_pkg::TDR_WIN_CYC
) (
  input  wire logic       CLK,
  input  wire logic       SYS_RST,
  input  wire logic       start,
  input  wire logic       fiber_mode,
  input  wire logic       partner_quiet,
  input  wire logic       echo_seen,
  input  wire logic       echo_short,
  output logic            busy,
  output logic            pulse_out,
  output logic [1:0]      result,
  output logic [8:0]      distance
);
  typedef enum logic [1:0] {
    CD_IDLE  = 2'b00,
    CD_QUIET = 2'b01,
    CD_PULSE = 2'b10,
    CD_LISTEN = 2'b11
  } pdpc_cd_e;

  pdpc_cd_e    st_q, st_d;
  logic [9:0]  cnt_q, cnt_d;
  logic [1:0]  res_q, res_d;
  logic [8:0]  dist_q, dist_d;

  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    res_d  = res_q;
    dist_d = dist_q;
    case (st_q)
      CD_IDLE: begin
        // copper only: fiber ports ignore the start request
        if (start && !fiber_mode) begin
          st_d  = CD_QUIET;
          cnt_d = 10'h000;
        end
      end
      CD_QUIET: begin
        if (partner_quiet) begin
          st_d  = CD_PULSE;
          cnt_d = 10'h000;
        end else if (cnt_q >= 10'(QUIET_CYC - 1)) begin
          res_d  = pdpc_pkg::RES_FAILED;
          dist_d = 9'h000;
          st_d   = CD_IDLE;
        end else begin
          cnt_d = cnt_q + 10'h001;
        end
      end
      CD_PULSE: begin
        st_d  = CD_LISTEN;
        cnt_d = 10'h000;
      end
      CD_LISTEN: begin
        // echo time is the fault distance count
        if (echo_seen) begin
          res_d  = echo_short ? pdpc_pkg::RES_SHORT : pdpc_pkg::RES_OPEN;
          dist_d = cnt_q[8:0];
          st_d   = CD_IDLE;
        end else if (cnt_q >= 10'(WIN_CYC - 1)) begin
          res_d  = pdpc_pkg::RES_NORMAL;
          dist_d = 9'h000;
          st_d   = CD_IDLE;
        end else begin
          cnt_d = cnt_q + 10'h001;
        end
      end
      default: st_d = CD_IDLE;
    endcase
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st_q   <= CD_IDLE;
      cnt_q  <= 10'h000;
      res_q  <= 2'h0;
      dist_q <= 9'h000;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      res_q  <= res_d;
      dist_q <= dist_d;
    end
  end

  assign busy      = (st_q != CD_IDLE);
  assign pulse_out = (st_q == CD_PULSE);
  assign result    = res_q;
  assign distance  = dist_q;
endmodule // pdpc_cable_diag
`default_nettype wire

// ==== rtl/pdpc_top.sv ====
// phy diagnostics and power control: registers, crossover, negotiation fallback, power modes
`timescale 1ns/1ps
`default_nettype none
module pdpc_top #(
  parameter int SLEEP_TICK = pdpc_pkg::SLEEP_TICK_CYC
) (
  input  wire logic       CLK,
  input  wire logic       SYS_RST,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  output logic      [7:0] REG_RDATA,
  input  wire logic [1:0] FIBER_MODE,
  input  wire logic [1:0] FIBER_SIGNAL_DETECT_IN,
  input  wire logic [1:0] FIBER_SD_HIGH_IN,
  input  wire logic [1:0] IDLE_GAP,
  input  wire logic [1:0] PARTNER_ADV_SEEN,
  input  wire logic [1:0] FIXED_SIG_100,
  input  wire logic [1:0] AUTONEG_EN,
  input  wire logic [1:0] CABLE_ENERGY,
  input  wire logic [1:0] PARTNER_QUIET,
  input  wire logic [1:0] ECHO_SEEN,
  input  wire logic [1:0] ECHO_SHORT,
  output logic      [1:0] FAR_END_FAULT,
  output logic      [1:0] FAULT_BIT_VALID,
  output logic      [1:0] FAULT_BIT_VALUE,
  output logic      [1:0] XOVER_AUTO_EN,
  output logic      [1:0] XOVER_STD_SCHEME,
  output logic      [1:0] TEST_PULSE,
  output logic      [1:0] PARALLEL_100,
  output logic      [1:0] PHY_POWER_EN,
  output logic      [1:0] RX_REDUCED,
  output logic            CLOCKS_EN,
  output logic            MAC_POWER_EN,
  output logic            HOST_IF_EN
);
  // pin-side inputs pass a two-stage synchroniser, apart from fiber mode, idle gap, autoneg enable and echo short
  localparam int NSYNC = 14;
  logic [NSYNC-1:0] raw_in, s1_q, s2_q;
  assign raw_in = {FIBER_SIGNAL_DETECT_IN, FIBER_SD_HIGH_IN, PARTNER_ADV_SEEN, FIXED_SIG_100,
                   CABLE_ENERGY, PARTNER_QUIET, ECHO_SEEN};
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= raw_in;
      s2_q <= s1_q;
    end
  end
  logic [1:0] sd_lo, sd_hi, adv_s, fix_s, nrg_s, quiet_s, echo_s;
  assign {sd_lo, sd_hi, adv_s, fix_s, nrg_s, quiet_s, echo_s} = s2_q;

  // register state
  logic [7:0] ctl_q [2];
  logic [7:0] ctl_d [2];
  logic [7:0] pwr_q, pwr_d, sleep_q, sleep_d, fib_q, fib_d;
  logic [1:0] start_q, start_d;
  logic [7:0] rdata_q, rdata_d;
  logic [1:0] busy, pulse;
  logic [1:0] cres [2];
  logic [8:0] cdist [2];
  logic [1:0] flt_v, flt_b;

  function automatic logic [1:0] port_of(input logic [7:0] a, input logic [7:0] o1, input logic [7:0] o2);
    port_of = {a == o2, a == o1};
  endfunction

  logic [1:0] hit_spc, hit_ctl, hit_res;
  assign hit_spc = port_of(REG_ADDR, pdpc_pkg::P1_SPECIAL_OFS, pdpc_pkg::P2_SPECIAL_OFS);
  assign hit_ctl = port_of(REG_ADDR, pdpc_pkg::P1_CTRL13_OFS, pdpc_pkg::P2_CTRL13_OFS);
  assign hit_res = port_of(REG_ADDR, pdpc_pkg::P1_RESULT_OFS, pdpc_pkg::P2_RESULT_OFS);

  always_comb begin
    pwr_d   = pwr_q;
    sleep_d = sleep_q;
    fib_d   = fib_q;
    for (int p = 0; p < 2; p++) begin
      ctl_d[p] = ctl_q[p];
      // start pulses one cycle; the sequencer itself holds busy
      start_d[p] = 1'b0;
      if (REG_WR && hit_ctl[p]) begin
        ctl_d[p] = REG_WDATA;
      end
      if (REG_WR && hit_spc[p] && REG_WDATA[pdpc_pkg::SPC_START_BIT] && !busy[p]) begin
        start_d[p] = 1'b1;
      end
    end
    if (REG_WR && REG_ADDR == pdpc_pkg::PWR_MGMT_OFS) begin
      pwr_d = REG_WDATA;
    end
    if (REG_WR && REG_ADDR == pdpc_pkg::SLEEP_DLY_OFS) begin
      sleep_d = REG_WDATA;
    end
    if (REG_WR && REG_ADDR == pdpc_pkg::FIBER_CFG_OFS) begin
      fib_d = REG_WDATA;
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rdata_d = 8'h00;
    if (REG_RD) begin
      for (int p = 0; p < 2; p++) begin
        if (hit_spc[p]) begin
          // start bit reads one until the test ends
          rdata_d = {1'b0, cres[p], busy[p] | start_q[p], 3'b000, cdist[p][8]};
        end
        if (hit_res[p]) begin
          rdata_d = cdist[p][7:0];
        end
        if (hit_ctl[p]) begin
          rdata_d = ctl_q[p];
        end
      end
      if (REG_ADDR == pdpc_pkg::PWR_MGMT_OFS) begin
        rdata_d = pwr_q;
      end
      if (REG_ADDR == pdpc_pkg::SLEEP_DLY_OFS) begin
        rdata_d = sleep_q;
      end
      if (REG_ADDR == pdpc_pkg::FIBER_CFG_OFS) begin
        rdata_d = fib_q;
      end
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ctl_q[0] <= pdpc_pkg::CTRL13_RST;
      ctl_q[1] <= pdpc_pkg::CTRL13_RST;
      pwr_q    <= pdpc_pkg::PWR_MGMT_RST;
      sleep_q  <= pdpc_pkg::SLEEP_DLY_RST;
      fib_q    <= pdpc_pkg::FIBER_CFG_RST;
      start_q  <= 2'b00;
      rdata_q  <= 8'h00;
    end else begin
      ctl_q[0] <= ctl_d[0];
      ctl_q[1] <= ctl_d[1];
      pwr_q    <= pwr_d;
      sleep_q  <= sleep_d;
      fib_q    <= fib_d;
      start_q  <= start_d;
      rdata_q  <= rdata_d;
    end
  end

  // per-port fault generator and cable sequencer
  logic [1:0] fault;
  for (genvar p = 0; p < 2; p++) begin : g_port
    // threshold select picks which detect comparator counts as signal
    assign fault[p] = FIBER_MODE[p] && fib_q[pdpc_pkg::FIB_FAULT_EN_BIT] &&
                      !(fib_q[pdpc_pkg::FIB_THR_BIT] ? sd_hi[p] : sd_lo[p]);
    pdpc_fault_tx u_flt (
      .CLK       (CLK),
      .SYS_RST   (SYS_RST),
      .fault     (fault[p]),
      .idle_gap  (IDLE_GAP[p]),
      .bit_valid (flt_v[p]),
      .bit_value (flt_b[p])
    );
    pdpc_cable_diag u_diag (
      .CLK           (CLK),
      .SYS_RST       (SYS_RST),
      .start         (start_q[p]),
      .fiber_mode    (FIBER_MODE[p]),
      .partner_quiet (quiet_s[p]),
      .echo_seen     (echo_s[p]),
      .echo_short    (ECHO_SHORT[p]),
      .busy          (busy[p]),
      .pulse_out     (pulse[p]),
      .result        (cres[p]),
      .distance      (cdist[p])
    );
  end

  // energy detect sleep timer: delay counts in ticks
  // any port with energy keeps the whole chip awake, so one live cable blocks sleep
  logic [31:0] tick_q, tick_d;
  logic [7:0]  quiet_q, quiet_d;
  logic        asleep_q, asleep_d;
  always_comb begin
    tick_d   = tick_q;
    quiet_d  = quiet_q;
    asleep_d = asleep_q;
    if (pwr_q[1:0] != pdpc_pkg::PWR_ENERGY || |nrg_s) begin
      tick_d   = 32'h0;
      quiet_d  = 8'h00;
      asleep_d = 1'b0;
    end else if (!asleep_q) begin
      if (tick_q >= 32'(SLEEP_TICK - 1)) begin
        tick_d = 32'h0;
        if (quiet_q >= sleep_q) begin
          asleep_d = 1'b1;
        end else begin
          quiet_d = quiet_q + 8'h01;
        end
      end else begin
        tick_d = tick_q + 32'h1;
      end
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      tick_q   <= 32'h0;
      quiet_q  <= 8'h00;
      asleep_q <= 1'b0;
    end else begin
      tick_q   <= tick_d;
      quiet_q  <= quiet_d;
      asleep_q <= asleep_d;
    end
  end

  // outputs, all registered
  logic [1:0] far_d, fv_d, fb_d, xa_d, xs_d, tp_d, p100_d, phy_d, rxr_d;
  logic       clk_d, mac_d, host_d;
  logic [1:0] far_q, fv_q, fb_q, xa_q, xs_q, tp_q, p100_q, phy_q, rxr_q;
  logic       clk_q, mac_q, host_q;
  logic       soft_dn;
  assign soft_dn = (pwr_q[1:0] == pdpc_pkg::PWR_SOFTDN);
  always_comb begin
    clk_d  = !soft_dn && !asleep_q;
    mac_d  = clk_d;
    host_d = clk_d;
    for (int p = 0; p < 2; p++) begin
      far_d[p]  = fault[p];
      fv_d[p]   = flt_v[p];
      fb_d[p]   = flt_b[p];
      xa_d[p]   = !ctl_q[p][pdpc_pkg::CTL_XOVER_DIS_BIT] && !FIBER_MODE[p];
      xs_d[p]   = ctl_q[p][pdpc_pkg::CTL_XOVER_STD_BIT];
      tp_d[p]   = pulse[p];
      // no advertisement: speed follows the fixed line signal
      p100_d[p] = adv_s[p] ? p100_q[p] : fix_s[p];
      phy_d[p]  = !ctl_q[p][pdpc_pkg::CTL_PWRDN_BIT] && clk_d;
      rxr_d[p]  = pwr_q[1:0] == pdpc_pkg::PWR_SAVING && AUTONEG_EN[p] && !nrg_s[p];
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      far_q  <= 2'b00;
      fv_q   <= 2'b00;
      fb_q   <= 2'b00;
      xa_q   <= 2'b00;
      xs_q   <= 2'b00;
      tp_q   <= 2'b00;
      p100_q <= 2'b00;
      phy_q  <= 2'b00;
      rxr_q  <= 2'b00;
      clk_q  <= 1'b0;
      mac_q  <= 1'b0;
      host_q <= 1'b0;
    end else begin
      far_q  <= far_d;
      fv_q   <= fv_d;
      fb_q   <= fb_d;
      xa_q   <= xa_d;
      xs_q   <= xs_d;
      tp_q   <= tp_d;
      p100_q <= p100_d;
      phy_q  <= phy_d;
      rxr_q  <= rxr_d;
      clk_q  <= clk_d;
      mac_q  <= mac_d;
      host_q <= host_d;
    end
  end

  assign REG_RDATA        = rdata_q;
  assign FAR_END_FAULT    = far_q;
  assign FAULT_BIT_VALID  = fv_q;
  assign FAULT_BIT_VALUE  = fb_q;
  assign XOVER_AUTO_EN    = xa_q;
  assign XOVER_STD_SCHEME = xs_q;
  assign TEST_PULSE       = tp_q;
  assign PARALLEL_100     = p100_q;
  assign PHY_POWER_EN     = phy_q;
  assign RX_REDUCED       = rxr_q;
  assign CLOCKS_EN        = clk_q;
  assign MAC_POWER_EN     = mac_q;
  assign HOST_IF_EN       = host_q;
endmodule // pdpc_top
`default_nettype wire

// ==== tb/pdpc_checker.sv ====
// assertion checker on the top ports of the phy diag/power block
`timescale 1ns/1ps
`default_nettype none
module pdpc_checker (
  input wire logic       CLK,
  input wire logic       SYS_RST,
  input wire logic       REG_RD,
  input wire logic [7:0] REG_RDATA,
  input wire logic [1:0] FIBER_MODE,
  input wire logic [1:0] IDLE_GAP,
  input wire logic [1:0] FAR_END_FAULT,
  input wire logic [1:0] FAULT_BIT_VALID,
  input wire logic [1:0] FAULT_BIT_VALUE,
  input wire logic [1:0] TEST_PULSE,
  input wire logic [1:0] RX_REDUCED,
  input wire logic       CLOCKS_EN,
  input wire logic       MAC_POWER_EN,
  input wire logic       HOST_IF_EN
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  logic [7:0] ones_q;
  logic [7:0] ones_d;
  // run of ones in the fault pattern; restarts on each zero, on a frame and whenever the fault drops
  always_comb begin
    ones_d = ones_q;
    if (!FAR_END_FAULT[0] || !FAULT_BIT_VALID[0] || !FAULT_BIT_VALUE[0]) ones_d = 8'h00;
    else ones_d = ones_q + 8'h01;
  end
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) ones_q <= 8'h00;
    else ones_q <= ones_d;
  end
  property p_copper_no_fault;
    (!FIBER_MODE[0]) [*4] |-> !FAR_END_FAULT[0];
  endproperty
  a_copper_no_fault: assert property (p_copper_no_fault) else $error("fault flag on copper port");
  property p_fault_gap;
    FAULT_BIT_VALID[0] |-> $past(IDLE_GAP[0], 2);
  endproperty
  a_fault_gap: assert property (p_fault_gap) else $error("fault pattern outside idle gap");
  property p_fault_zero;
    FAR_END_FAULT[0] && FAULT_BIT_VALID[0] && !FAULT_BIT_VALUE[0] |-> ones_q == 8'h54;
  endproperty
  a_fault_zero: assert property (p_fault_zero) else $error("fault zero after wrong count of ones");
  property p_fault_max;
    FAULT_BIT_VALID[0] && FAULT_BIT_VALUE[0] |-> ones_q < 8'h54;
  endproperty
  a_fault_max: assert property (p_fault_max) else $error("fault pattern has too many ones");
  property p_pulse_copper;
    TEST_PULSE[1] |-> !FIBER_MODE[1];
  endproperty
  a_pulse_copper: assert property (p_pulse_copper) else $error("test pulse on fiber port");
  property p_pulse_single;
    TEST_PULSE[0] |=> !TEST_PULSE[0];
  endproperty
  a_pulse_single: assert property (p_pulse_single) else $error("test pulse longer than one cycle");
  property p_saving_on;
    RX_REDUCED[0] |-> CLOCKS_EN && MAC_POWER_EN && HOST_IF_EN;
  endproperty
  a_saving_on: assert property (p_saving_on) else $error("power saving turned clocks or mac off");
  property p_rdata_idle;
    !$past(REG_RD) |-> REG_RDATA == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");
  property p_reset_up;
    $fell(SYS_RST) |=> CLOCKS_EN && MAC_POWER_EN && HOST_IF_EN;
  endproperty
  a_reset_up: assert property (p_reset_up) else $error("not in normal mode after reset");
endmodule // pdpc_checker
bind pdpc_top pdpc_checker pdpc_checker_inst (.CLK, .SYS_RST, .REG_RD, .REG_RDATA, .FIBER_MODE, .IDLE_GAP,
  .FAR_END_FAULT, .FAULT_BIT_VALID, .FAULT_BIT_VALUE, .TEST_PULSE, .RX_REDUCED, .CLOCKS_EN, .MAC_POWER_EN,
  .HOST_IF_EN);
`default_nettype wire

// ==== tb/pdpc_link_partner.sv ====
// cable link partner model: silences itself on request and echoes the test pulse
`timescale 1ns/1ps
`default_nettype none
module pdpc_link_partner (
  input  wire logic       CLK,
  input  wire logic       pulse,
  input  wire logic       go_quiet,
  input  wire logic       echo_on,
  input  wire logic       is_short,
  input  wire logic [9:0] dly,
  output logic            quiet,
  output logic            echo,
  output logic            short_flag
);
  logic [10:0] cnt_q = 11'h000;
  // echo lasts four cycles so the two-stage synchroniser cannot miss it
  always @(posedge CLK) begin
    if (pulse && echo_on) cnt_q <= {1'b0, dly} + 11'h004;
    else if (cnt_q != 11'h000) cnt_q <= cnt_q - 11'h001;
  end
  assign echo = (cnt_q != 11'h000) && (cnt_q <= 11'h004);
  assign quiet = go_quiet;
  assign short_flag = is_short;
endmodule // pdpc_link_partner
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking testbench for the phy diag/power block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk, rst, wr, rd;
  logic [7:0] addr, wdata, rdata, v;
  logic [1:0] fm, sd, sdh, gap, adv, fix, an, energy, quiet, echo, eshort;
  logic [1:0] far, fbv, fbval, xa, xs, tp, p100, phy, rxr, q_cfg, e_cfg, s_cfg;
  logic [9:0] d_cfg [2];
  logic clk_en, mac, host;
  int miscompares = 0;
  int n_tests = 0;
  int n;
  pdpc_top #(.SLEEP_TICK(4)) pdpc_top_inst (.CLK(clk), .SYS_RST(rst), .REG_WR(wr), .REG_RD(rd),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata), .FIBER_MODE(fm), .FIBER_SIGNAL_DETECT_IN(sd),
    .FIBER_SD_HIGH_IN(sdh), .IDLE_GAP(gap), .PARTNER_ADV_SEEN(adv), .FIXED_SIG_100(fix), .AUTONEG_EN(an),
    .CABLE_ENERGY(energy), .PARTNER_QUIET(quiet), .ECHO_SEEN(echo), .ECHO_SHORT(eshort),
    .FAR_END_FAULT(far), .FAULT_BIT_VALID(fbv), .FAULT_BIT_VALUE(fbval), .XOVER_AUTO_EN(xa),
    .XOVER_STD_SCHEME(xs), .TEST_PULSE(tp), .PARALLEL_100(p100), .PHY_POWER_EN(phy), .RX_REDUCED(rxr),
    .CLOCKS_EN(clk_en), .MAC_POWER_EN(mac), .HOST_IF_EN(host));
  for (genvar g = 0; g < 2; g++) begin : g_lp
    pdpc_link_partner pdpc_link_partner_inst (.CLK(clk), .pulse(tp[g]), .go_quiet(q_cfg[g]),
      .echo_on(e_cfg[g]), .is_short(s_cfg[g]), .dly(d_cfg[g]), .quiet(quiet[g]), .echo(echo[g]),
      .short_flag(eshort[g]));
  end
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic idle(input int c);
    repeat (c) @(negedge clk);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    rd = 1'b1;
    addr = a;
    @(negedge clk);
    rd = 1'b0;
    d = rdata;
  endtask
  task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_rng(input string nm, input logic [8:0] lo, input logic [8:0] hi, input logic [8:0] g);
    n_tests++;
    if ($isunknown(g) || g < lo || g > hi) begin
      miscompares++;
      $display("BAD %s expected %h..%h seen %h", nm, lo, hi, g);
    end
  endtask
  // one cable test on port p, polling the start bit as software must before reading results
  task automatic cable(input int p, input logic q, input logic e, input logic s, input logic [9:0] dl,
                       input logic [1:0] er, input logic [8:0] lo, input logic [8:0] hi);
    logic [7:0] sa;
    logic [7:0] r;
    sa = p ? pdpc_pkg::P2_SPECIAL_OFS : pdpc_pkg::P1_SPECIAL_OFS;
    q_cfg[p] = q;
    e_cfg[p] = e;
    s_cfg[p] = s;
    d_cfg[p] = dl;
    wreg(sa + 8'h03, 8'h04);
    wreg(sa, 8'h10);
    rreg(sa, v);
    chk("start bit", 9'h001, {8'h00, v[4]});
    chk("auto xover", 9'h000, {8'h00, xa[p]});
    wreg(sa, 8'h10);
    for (int i = 0; i < 600 && v[4] !== 1'b0; i++) rreg(sa, v);
    chk("start clear", 9'h000, {8'h00, v[4]});
    chk("result", {7'h00, er}, {7'h00, v[6:5]});
    rreg(sa + 8'h01, r);
    chk_rng("distance", lo, hi, {v[0], r});
    wreg(sa + 8'h03, 8'h00);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #400000;
    miscompares++;
    give_verdict();
  end
  initial begin
    {wr, rd, addr, wdata, fm, sd, sdh, gap, adv, fix} = '0;
    {q_cfg, e_cfg, s_cfg, d_cfg[0], d_cfg[1]} = '0;
    an = 2'h3;
    energy = 2'h3;
    rst = 1'b1;
    idle(2);
    rst = 1'b0;
    rreg(pdpc_pkg::PWR_MGMT_OFS, v);
    chk("power mode", {1'b0, pdpc_pkg::PWR_MGMT_RST}, {1'b0, v});
    rreg(pdpc_pkg::FIBER_CFG_OFS, v);
    chk("fiber cfg", {1'b0, pdpc_pkg::FIBER_CFG_RST}, {1'b0, v});
    rreg(8'h55, v);
    chk("unmapped", 9'h000, {1'b0, v});
    chk("xover", 9'h00C, {5'h00, xa, xs});
    chk("power up", 9'h01F, {4'h0, clk_en, mac, host, phy});
    wreg(pdpc_pkg::P1_CTRL13_OFS, 8'h18);
    idle(3);
    chk("std scheme and port down", 9'h006, {5'h00, xs, phy});
    wreg(pdpc_pkg::P1_CTRL13_OFS, 8'h00);
    fix = 2'h1;
    idle(5);
    chk("parallel detect", 9'h001, {7'h00, p100});
    fix = 2'h2;
    idle(5);
    chk("parallel detect", 9'h002, {7'h00, p100});
    adv = 2'h3;
    fix = 2'h1;
    idle(5);
    chk("advertised hold", 9'h002, {7'h00, p100});
    adv = 2'h0;
    cable(0, 1'b1, 1'b1, 1'b0, 10'h014, pdpc_pkg::RES_OPEN, 9'h012, 9'h01A);
    cable(0, 1'b1, 1'b1, 1'b1, 10'h12C, pdpc_pkg::RES_SHORT, 9'h12A, 9'h132);
    cable(1, 1'b1, 1'b0, 1'b0, 10'h000, pdpc_pkg::RES_NORMAL, 9'h000, 9'h000);
    cable(1, 1'b0, 1'b1, 1'b0, 10'h014, pdpc_pkg::RES_FAILED, 9'h000, 9'h000);
    fm = 2'h2;
    wreg(pdpc_pkg::P2_SPECIAL_OFS, 8'h10);
    idle(10);
    rreg(pdpc_pkg::P2_SPECIAL_OFS, v);
    chk("fiber start", 9'h000, {8'h00, v[4]});
    fm = 2'h1;
    gap = 2'h1;
    idle(6);
    chk("fault", 9'h001, {8'h00, far[0]});
    for (int i = 0; i < 400 && !(fbv[0] === 1'b1 && fbval[0] === 1'b0); i++) idle(1);
    idle(1);
    for (n = 0; n < 200 && fbval[0] === 1'b1; n++) idle(1);
    chk("ones", 9'h054, n[8:0]);
    sd = 2'h1;
    idle(6);
    chk("low threshold", 9'h000, {8'h00, far[0]});
    wreg(pdpc_pkg::FIBER_CFG_OFS, 8'h60);
    idle(6);
    chk("high threshold", 9'h001, {8'h00, far[0]});
    wreg(pdpc_pkg::FIBER_CFG_OFS, 8'h40);
    idle(6);
    chk("fault off", 9'h000, {8'h00, far[0]});
    wreg(pdpc_pkg::FIBER_CFG_OFS, 8'h20);
    {fm, gap, sd} = '0;
    wreg(pdpc_pkg::PWR_MGMT_OFS, {6'h00, pdpc_pkg::PWR_SOFTDN});
    idle(3);
    chk("soft down", 9'h000, {4'h0, clk_en, mac, host, phy});
    rreg(pdpc_pkg::PWR_MGMT_OFS, v);
    chk("kept mode", 9'h002, {1'b0, v});
    wreg(pdpc_pkg::PWR_MGMT_OFS, {6'h00, pdpc_pkg::PWR_NORMAL});
    idle(3);
    chk("restored", 9'h01F, {4'h0, clk_en, mac, host, phy});
    energy = 2'h0;
    wreg(pdpc_pkg::PWR_MGMT_OFS, {6'h00, pdpc_pkg::PWR_SAVING});
    idle(5);
    chk("saving", 9'h007, {6'h00, clk_en, rxr});
    energy = 2'h1;
    an = 2'h2;
    idle(5);
    chk("saving cable in", 9'h006, {6'h00, clk_en, rxr});
    an = 2'h3;
    energy = 2'h0;
    wreg(pdpc_pkg::SLEEP_DLY_OFS, 8'h02);
    wreg(pdpc_pkg::PWR_MGMT_OFS, {6'h00, pdpc_pkg::PWR_ENERGY});
    idle(6);
    chk("awake", 9'h001, {8'h00, clk_en});
    idle(20);
    chk("asleep", 9'h000, {8'h00, clk_en});
    energy = 2'h3;
    idle(6);
    chk("woken", 9'h001, {8'h00, clk_en});
    wreg(pdpc_pkg::PWR_MGMT_OFS, {6'h00, pdpc_pkg::PWR_NORMAL});
    give_verdict();
  end
endmodule // tb
`default_nettype wire
